// ---- logic/pss_host.sv ----
// Purpose: Host end: issues instructions and reads words over the link.
// Assumes: clk at 125 MHz; serial clock derived here and idles high.
// Notes:   One command at a time; conversions poll the output line.
`timescale 1ns/10ps
module pss_host
  import pss_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Command side
  input  wire logic              cmd_valid,
  input  pss_cmd_e               cmd_code,
  input  wire logic [3:0]        cmd_coef_idx,
  output logic                   cmd_ready,
  // Answer side
  output logic                   rsp_valid,
  output logic [WORD_W-1:0]      rsp_data,
  // Serial link
  pss_link_if.host               link
);
  typedef enum {H_IDLE, H_SEND, H_POLL, H_READ, H_GAP} pss_hstate_e;

  pss_hstate_e       state_reg;
  logic [15:0]       half_cnt_reg;
  logic              phase_hi_reg;
  logic [23:0]       tx_reg;
  logic [4:0]        left_reg;
  logic              got_bit_reg;
  logic [1:0]        kind_reg;
  logic [WORD_W-1:0] rx_reg;
  logic              sclk_reg;
  logic              cs_n_reg;
  logic              sdi_reg;
  logic              ready_reg;
  logic              rsp_valid_reg;
  logic              sdo_s;
  logic              tick;

  // Output line is another domain: filtered before use
  pss_sync3 #(.INIT(1'b1)) u_sdo_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (link.sdo_line),
    .q       (sdo_s)
  );

  assign tick = (half_cnt_reg == 16'(HALF_CYC - 1));

  // Half-period timer, restarted at each tick and in idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      half_cnt_reg <= 16'h0000;
    end else if (state_reg == H_IDLE || tick) begin
      half_cnt_reg <= 16'h0000;
    end else begin
      half_cnt_reg <= half_cnt_reg + 16'h0001;
    end
  end

  // Sequencer; the serial clock is made here by division, never by the device
  // host makes the clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= H_IDLE;
      phase_hi_reg  <= 1'b1;
      tx_reg        <= 24'h000000;
      left_reg      <= 5'd0;
      got_bit_reg   <= 1'b0;
      kind_reg      <= 2'd0;
      rx_reg        <= '0;
      sclk_reg      <= 1'b1;
      cs_n_reg      <= 1'b1;
      sdi_reg       <= 1'b0;
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid) begin
            cs_n_reg     <= 1'b0;
            phase_hi_reg <= 1'b1;
            kind_reg     <= cmd_code;
            state_reg    <= H_SEND;
            case (cmd_code)
              PSS_CMD_PRESS: begin
                tx_reg   <= {OP_CONV, OP_PRESS, PAD_BYTE};
                left_reg <= 5'd16;
              end
              PSS_CMD_TEMP: begin
                tx_reg   <= {OP_CONV, OP_TEMP, PAD_BYTE};
                left_reg <= 5'd16;
              end
              PSS_CMD_COEF: begin
                tx_reg   <= {OP_COEF, pss_coef_byte(cmd_coef_idx), PAD_BYTE};
                left_reg <= 5'd16;
              end
              default: begin
                tx_reg   <= {RST_B0, RST_B1, RST_B2};
                left_reg <= 5'd24;
              end
            endcase
          end
        end
        H_SEND: begin
          if (tick && !phase_hi_reg) begin
            sclk_reg     <= 1'b1;
            phase_hi_reg <= 1'b1;
          end else if (tick && left_reg != 5'd0) begin
            // Data changes on the falling edge for the device to take on rise
            sclk_reg     <= 1'b0;
            phase_hi_reg <= 1'b0;
            sdi_reg      <= tx_reg[23];
            tx_reg       <= {tx_reg[22:0], 1'b0};
            left_reg     <= left_reg - 5'd1;
          end else if (tick) begin
            // Last bit held to the next fall so it never moves under a high clock
            left_reg    <= 5'd16;
            got_bit_reg <= 1'b0;
            case (kind_reg)
              2'(PSS_CMD_COEF):  state_reg <= H_READ;
              2'(PSS_CMD_RESET): state_reg <= H_GAP;
              default:           state_reg <= H_POLL;
            endcase
          end
        end
        H_POLL: begin
          // A full half period lets the filtered line catch up first
          // wait for ready low
          if (tick && !sdo_s) begin
            state_reg <= H_READ;
          end
        end
        H_READ: begin
          if (tick && !phase_hi_reg) begin
            sclk_reg     <= 1'b1;
            phase_hi_reg <= 1'b1;
          end else if (tick) begin
            // Sample at the end of the high half, where the bit is settled
            if (got_bit_reg) begin
              rx_reg <= {rx_reg[WORD_W-2:0], sdo_s};
            end
            if (left_reg != 5'd0) begin
              sclk_reg     <= 1'b0;
              phase_hi_reg <= 1'b0;
              sdi_reg      <= 1'b0;
              got_bit_reg  <= 1'b1;
              left_reg     <= left_reg - 5'd1;
            end else begin
              rsp_valid_reg <= 1'b1;
              state_reg     <= H_GAP;
            end
          end
        end
        H_GAP: begin
          cs_n_reg <= 1'b1;
          if (tick && cs_n_reg) begin
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // Ready one cycle after returning to idle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= (state_reg == H_IDLE) && !cmd_valid;
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.sdi  = sdi_reg;
  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data  = rx_reg;
endmodule : pss_host

// ---- logic/pss_pkg.sv ----
// Purpose: Shared constants, types and helpers for the sensor serial readout.
// Assumes: Host logic clocked at 125 MHz, conversion clock at 32768 Hz.
// Notes:   Instruction bytes travel most significant bit first.
package pss_pkg;

  // Word sizes
  localparam int WORD_W   = 16;
  localparam int BYTE_W   = 8;
  localparam int COEF_NUM = 10;

  // Instruction bytes
  localparam logic [7:0] OP_CONV   = 8'h0F;
  localparam logic [7:0] OP_PRESS  = 8'h51;
  localparam logic [7:0] OP_TEMP   = 8'h21;
  localparam logic [7:0] OP_COEF   = 8'h1C;
  localparam logic [7:0] COEF_BASE = 8'h40;
  localparam logic [7:0] COEF_LAST = 8'hD0;
  localparam logic [7:0] RST_B0    = 8'h0A;
  localparam logic [7:0] RST_B1    = 8'hAA;
  localparam logic [7:0] RST_B2    = 8'hA0;
  localparam logic [7:0] PAD_BYTE  = 8'h00;

  // Host clock and serial clock limit
  localparam int CLK_KHZ       = 125000;
  localparam int SCLK_MAX_KHZ  = 500;
  // Least half period of the serial clock, rounded up
  localparam int SCLK_HALF_CYC = (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);

  // Conversion time at the nominal conversion clock
  localparam longint CONV_TIME_US = 34500;
  localparam longint CONV_CLK_HZ  = 32768;
  localparam int     CONV_CYCLES  = int'((CONV_TIME_US * CONV_CLK_HZ) / 1000000);

  // Host command codes
  typedef enum logic [1:0] {
    PSS_CMD_PRESS,
    PSS_CMD_TEMP,
    PSS_CMD_COEF,
    PSS_CMD_RESET
  } pss_cmd_e;

  // True for a coefficient address byte
  function automatic logic pss_is_coef(input logic [7:0] b);
    return (b[3:0] == 4'h0) && (b >= COEF_BASE) && (b <= COEF_LAST);
  endfunction : pss_is_coef

  // Coefficient index (0..9) from an address byte
  function automatic logic [3:0] pss_coef_idx(input logic [7:0] b);
    return b[7:4] - COEF_BASE[7:4];
  endfunction : pss_coef_idx

  // Address byte from a coefficient index
  function automatic logic [7:0] pss_coef_byte(input logic [3:0] idx);
    return COEF_BASE + {idx, 4'h0};
  endfunction : pss_coef_byte

endpackage : pss_pkg

// ---- logic/pss_link_if.sv ----
// Purpose: Four-wire serial link between host and sensor.
// Assumes: Output line floats high through a pull-up when nobody drives it.
// Notes:   Resolves the shared output line from its enable.
`timescale 1ns/10ps
interface pss_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo_d;
  logic sdo_oe;
  logic sdo_line;

  // Pull-up when the driver is off
  assign sdo_line = sdo_oe ? sdo_d : 1'b1;

  modport dev  (input sclk, input cs_n, input sdi, output sdo_d, output sdo_oe);
  modport host (output sclk, output cs_n, output sdi, input sdo_line);
endinterface : pss_link_if

// ---- logic/pss_sync3.sv ----
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk.
// Notes:   Output changes once stages two and three agree.
`timescale 1ns/10ps
module pss_sync3
  import pss_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Data
  input  wire logic d,
  output logic      q
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic q_reg;

  // Chain; first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a level only when two stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q_reg <= INIT;
    end else if (s2_reg == s3_reg) begin
      q_reg <= s3_reg;
    end
  end

  assign q = q_reg;
endmodule : pss_sync3

// ---- logic/pss_device.sv ----
// Purpose: Sensor end of the serial link: instruction decode, conversion
//          timing, result and coefficient readout.
// Assumes: Serial clock idles high; conversion clock runs free.
// Notes:   Analog path is replaced by sample inputs taken at conversion end.
`timescale 1ns/10ps
module pss_device
  import pss_pkg::*;
#(
  parameter int                CONV_CYC = CONV_CYCLES,
  parameter logic [WORD_W-1:0] COEFF_WORDS [COEF_NUM] = '{
    16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555,
    16'h6666, 16'h7777, 16'h8888, 16'h9999, 16'hAAAA}
) (
  // Power-on reset and conversion clock
  input  wire logic              reset_n,
  input  wire logic              conversion_clock,
  // Stand-in for the analog front end
  input  wire logic [WORD_W-1:0] pressure_sample,
  input  wire logic [WORD_W-1:0] temperature_sample,
  output logic                   conv_busy,
  // Serial link
  // fixed serial type, no strap
  pss_link_if.dev                link
);
  // Link-side state, rising edge
  logic [2:0]        bit_cnt_reg;
  logic [6:0]        in_shift_reg;
  logic [7:0]        byte1_reg;
  logic [7:0]        byte2_reg;
  logic              start_tgl_reg;
  logic              chan_press_reg;
  logic              arm_tgl_reg;
  logic              sel_coef_reg;
  logic [3:0]        coef_idx_reg;
  // Link-side state, falling edge
  logic              take_tgl_reg;
  logic              out_active_reg;
  logic [3:0]        out_cnt_reg;
  logic [WORD_W-1:0] out_shift_reg;
  // Conversion-side state
  logic              start_s;
  logic              done_tgl_reg;
  logic              busy_reg;
  logic              conv_press_reg;
  logic [15:0]       conv_cnt_reg;
  logic [WORD_W-1:0] result_reg;
  // Combinational helpers
  logic              frame_rst_n;
  logic              byte_done;
  logic [7:0]        byte_now;
  logic              conv_pending;
  logic [WORD_W-1:0] otp_mem [COEF_NUM];
  logic [WORD_W-1:0] load_word;

  // One-time-programmable coefficients, read only
  // unsigned coefficient words
  assign otp_mem = COEFF_WORDS;

  // Select high ends a frame and realigns the byte counter; with select tied
  // low the counter simply runs on in eight-bit steps.
  // frame realignment
  assign frame_rst_n = reset_n & ~link.cs_n;
  assign byte_done   = (bit_cnt_reg == 3'd7);
  assign byte_now    = {in_shift_reg, link.sdi};

  // Input bits taken on the rising edge, only inside a frame
  // sample on rising edge
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg  <= 3'd0;
      in_shift_reg <= 7'h00;
      byte1_reg    <= 8'h00;
      byte2_reg    <= 8'h00;
    end else begin
      bit_cnt_reg  <= bit_cnt_reg + 3'd1;
      in_shift_reg <= byte_now[6:0];
      if (byte_done) begin
        byte1_reg <= byte_now;
        byte2_reg <= byte1_reg;
      end
    end
  end

  // Conversion still owed to the link while the toggles differ. Both toggles
  // are quasi-static across the compare: each moves once per conversion.
  assign conv_pending = (start_tgl_reg != done_tgl_reg);

  // Instruction decode on each completed byte
  // channel and memory decode
  always_ff @(posedge link.sclk or negedge reset_n) begin
    if (!reset_n) begin
      start_tgl_reg  <= 1'b0;
      chan_press_reg <= 1'b0;
      arm_tgl_reg    <= 1'b0;
      sel_coef_reg   <= 1'b0;
      coef_idx_reg   <= 4'h0;
    end else if (byte_done && !link.cs_n) begin
      if (byte1_reg == OP_CONV && (byte_now == OP_PRESS || byte_now == OP_TEMP)
          && !conv_pending) begin
        start_tgl_reg  <= ~start_tgl_reg;
        chan_press_reg <= (byte_now == OP_PRESS);
        sel_coef_reg   <= 1'b0;
        arm_tgl_reg    <= ~take_tgl_reg;
      end else if (byte1_reg == OP_COEF && pss_is_coef(byte_now)) begin
        sel_coef_reg <= 1'b1;
        coef_idx_reg <= pss_coef_idx(byte_now);
        arm_tgl_reg  <= ~take_tgl_reg;
      // reset sequence drops any pending read
      end else if (byte2_reg == RST_B0 && byte1_reg == RST_B1 && byte_now == RST_B2) begin
        sel_coef_reg <= 1'b0;
        arm_tgl_reg  <= take_tgl_reg;
      end
    end
  end

  assign load_word = sel_coef_reg ? otp_mem[coef_idx_reg] : result_reg;

  // Output shifter on the falling edge; a conversion read waits for the
  // result, a coefficient read starts at once.
  // change on falling edge
  always_ff @(negedge link.sclk or negedge reset_n) begin
    if (!reset_n) begin
      take_tgl_reg   <= 1'b0;
      out_active_reg <= 1'b0;
      out_cnt_reg    <= 4'h0;
      out_shift_reg  <= '0;
    end else if (out_active_reg) begin
      if (out_cnt_reg == 4'h0) begin
        out_active_reg <= 1'b0;
      end else begin
        out_shift_reg <= {out_shift_reg[WORD_W-2:0], 1'b0};
        out_cnt_reg   <= out_cnt_reg - 4'h1;
      end
    end else if (!link.cs_n && arm_tgl_reg != take_tgl_reg
                 && (sel_coef_reg || !conv_pending)) begin
      take_tgl_reg   <= arm_tgl_reg;
      out_active_reg <= 1'b1;
      out_cnt_reg    <= 4'(WORD_W - 1);
      out_shift_reg  <= load_word;
    end
  end

  // Output line: data while shifting, otherwise end-of-conversion flag.
  // The driver follows the select pin directly so it floats at once.
  // float while deselected
  assign link.sdo_d  = out_active_reg ? out_shift_reg[WORD_W-1] : conv_pending;
  assign link.sdo_oe = ~link.cs_n;

  // Start request crosses into the conversion domain
  pss_sync3 #(.INIT(1'b0)) u_start_sync (
    .clk     (conversion_clock),
    .reset_n (reset_n),
    .d       (start_tgl_reg),
    .q       (start_s)
  );

  // Conversion timer on the conversion clock
  // timed by conversion clock
  always_ff @(posedge conversion_clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg       <= 1'b0;
      done_tgl_reg   <= 1'b0;
      conv_press_reg <= 1'b0;
      conv_cnt_reg   <= 16'h0000;
      result_reg     <= '0;
    end else if (!busy_reg) begin
      if (start_s != done_tgl_reg) begin
        busy_reg       <= 1'b1;
        conv_press_reg <= chan_press_reg;
        conv_cnt_reg   <= 16'(CONV_CYC - 1);
      end
    end else if (conv_cnt_reg == 16'h0000) begin
      busy_reg     <= 1'b0;
      done_tgl_reg <= start_s;
      result_reg   <= conv_press_reg ? pressure_sample : temperature_sample;
    end else begin
      conv_cnt_reg <= conv_cnt_reg - 16'h0001;
    end
  end

  assign conv_busy = busy_reg;
endmodule : pss_device

// ---- verif/pss_link_assertions.sv ----
// Purpose: Checker for the wires between host and sensor ends.
// Assumes: Sampled on the host clock; serial half period of 4 cycles.
// Notes:   Watches interface signals only, so it judges both ends.
`timescale 1ns/10ps
module pss_link_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic sdo_d,
  input wire logic sdo_oe,
  input wire logic sdo_line
);
  logic       sclk_q;
  logic [2:0] rise_cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Delayed serial clock to find its rising edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
    end
  end

  // Rises within a frame; only the low three bits matter for byte framing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_cnt <= 3'h0;
    end else if (cs_n) begin
      rise_cnt <= 3'h0;
    end else if (sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 3'h1;
    end
  end

  a_sdo_float: assert property (cs_n |-> !sdo_oe && sdo_line)
    else $error("output driven while deselected");
  a_sdo_drive: assert property (!cs_n |-> sdo_oe && (sdo_line == sdo_d))
    else $error("output not driven while selected");
  a_sdo_hold: assert property (!cs_n && !sclk && !$past(sclk) |-> $stable(sdo_d))
    else $error("output changed away from falling edge");
  a_sclk_idle: assert property (cs_n |-> sclk)
    else $error("serial clock not idle outside frame");
  a_sclk_half: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("serial clock half period too short");
  a_sdi_setup: assert property (!cs_n && !$past(cs_n) && $changed(sdi) |-> !sclk)
    else $error("input data changed while clock high");
  a_frame_edge: assert property ($changed(cs_n) |-> sclk)
    else $error("select moved while clock low");
  a_byte_frame: assert property ($rose(cs_n) |-> rise_cnt == 3'h0)
    else $error("frame ended on a partial byte");
endmodule : pss_link_assertions

// ---- verif/test_pressure_sensor_spi_readout.sv ----
// Purpose: Host and sensor ends joined; results compared with a queue model.
// Assumes: Short half period and conversion count for run time.
// Notes:   Coefficient table is arbitrary test data.
`timescale 1ns/10ps
module test_pressure_sensor_spi_readout
  import pss_pkg::*;
;
  localparam logic [WORD_W-1:0] COEF_TAB [COEF_NUM] = '{
    16'h1A2B, 16'h2C3D, 16'h3E4F, 16'h8051, 16'h5263,
    16'h6475, 16'h7687, 16'hF899, 16'h9AAB, 16'hACBD};
  logic              clk, conversion_clock, reset_n, cmd_valid, cmd_ready, rsp_valid, conv_busy;
  pss_cmd_e          cmd_code;
  logic [3:0]        cmd_coef_idx;
  logic [WORD_W-1:0] rsp_data, pressure_sample, temperature_sample;
  logic [WORD_W-1:0] exp_q [$];
  int                err_total, total_checks, got_cnt, exp_n, n;

  pss_link_if lk ();
  pss_host #(.HALF_CYC(4)) pss_host_inst (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_coef_idx(cmd_coef_idx),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(lk.host));
  pss_device #(.CONV_CYC(5), .COEFF_WORDS(COEF_TAB)) pss_device_inst (.reset_n(reset_n),
    .conversion_clock(conversion_clock), .pressure_sample(pressure_sample),
    .temperature_sample(temperature_sample), .conv_busy(conv_busy), .link(lk.dev));
  pss_link_assertions pss_link_assertions_inst (.clk(clk), .reset_n(reset_n),
    .sclk(lk.sclk), .cs_n(lk.cs_n), .sdi(lk.sdi), .sdo_d(lk.sdo_d), .sdo_oe(lk.sdo_oe),
    .sdo_line(lk.sdo_line));

  // Clocks; conversion clock offset so the two never line up
  initial clk = 1'b0;
  always #4 clk = ~clk;
  initial begin
    conversion_clock = 1'b0;
    #5.3;
    forever #32 conversion_clock = ~conversion_clock;
  end

  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] expv);
    total_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Every answer is counted and, while one is queued, checked against the oldest expected word
  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      got_cnt++;
      if (exp_q.size() > 0) begin
        check(rsp_data, exp_q.pop_front());
      end
    end
  end

  // Reset held three clock cycles; every flop in both domains resets asynchronously
  task automatic do_reset();
    @(negedge clk);
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    exp_q.delete();
    got_cnt = exp_n;
    check(16'({lk.cs_n, lk.sclk, lk.sdo_line}), 16'h7);
    repeat (2) @(negedge clk);
    check(16'(cmd_ready), 16'h1);
  endtask : do_reset

  task automatic wait_ready();
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 20000) begin
        err_total++;
        results();
      end
    end
  endtask : wait_ready

  // Hold the request until the host leaves idle, then drop it
  task automatic send(input pss_cmd_e code, input logic [3:0] idx);
    wait_ready();
    @(negedge clk);
    cmd_code     = code;
    cmd_coef_idx = idx;
    cmd_valid    = 1'b1;
    while (cmd_ready !== 1'b0) @(negedge clk);
    cmd_valid = 1'b0;
  endtask : send

  task automatic end_test(input int t);
    wait_ready();
    check(16'(got_cnt), 16'(exp_n));
    $display("test %0d done", t);
  endtask : end_test

  initial begin
    #400000;
    err_total++;
    results();
  end

  initial begin
    pss_cmd_e code;
    reset_n            = 1'b0;
    cmd_valid          = 1'b0;
    cmd_code           = PSS_CMD_PRESS;
    cmd_coef_idx       = 4'h0;
    pressure_sample    = 16'h0000;
    temperature_sample = 16'h0000;
    err_total          = 0;
    total_checks       = 0;
    got_cnt            = 0;
    exp_n              = 0;
    void'($urandom(32'hD3C7393B));
    do_reset();
    end_test(1);
    // All ten coefficients; a stray request while the read instruction is sent must be ignored
    for (int i = 0; i < COEF_NUM; i++) begin
      exp_q.push_back(COEF_TAB[i]);
      exp_n++;
      send(PSS_CMD_COEF, 4'(i));
      if (i == 3) begin
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code  = PSS_CMD_PRESS;
        repeat (6) @(negedge clk);
        cmd_valid = 1'b0;
      end
    end
    end_test(2);
    // Pressure and temperature conversions with random samples
    for (int i = 0; i < 8; i++) begin
      code = pss_cmd_e'(i < 2 ? i : $urandom_range(1));
      wait_ready();
      @(negedge clk);
      pressure_sample    = 16'($urandom);
      temperature_sample = 16'($urandom);
      exp_q.push_back(code == PSS_CMD_PRESS ? pressure_sample : temperature_sample);
      exp_n++;
      send(code, 4'($urandom));
      n = 0;
      while (conv_busy !== 1'b1 && n < 3000) begin
        @(negedge clk);
        n++;
      end
      check(16'(conv_busy), 16'h1);
      repeat (2) @(posedge conversion_clock);
      @(negedge clk);
      check(16'(lk.sdo_line), 16'h1);
    end
    end_test(3);
    // Reset sequence gives no answer; a read still works after it
    send(PSS_CMD_RESET, 4'h0);
    exp_q.push_back(COEF_TAB[9]);
    exp_n++;
    send(PSS_CMD_COEF, 4'h9);
    end_test(4);
    // Reset both ends while the read instruction is still being sent, then read again
    send(PSS_CMD_COEF, 4'h5);
    repeat (40) @(negedge clk);
    do_reset();
    exp_q.push_back(COEF_TAB[5]);
    exp_n++;
    send(PSS_CMD_COEF, 4'h5);
    end_test(5);
    results();
  end
endmodule : test_pressure_sensor_spi_readout
